/* File: adcs_pkg.sv */
/*
 * Constants, types and register map of the conversion sequencer.
 * Assumes a 32-bit APB master and a converter core on the same clock.
 */
`default_nettype none

package adcs_pkg;

    // ------------------------------------------------------------------
    // register byte addresses
    // ------------------------------------------------------------------
    localparam logic [31:0] ADDR_CCS = 32'h4003_B000;
    localparam logic [31:0] ADDR_CTC = 32'h4003_B004;
    localparam logic [31:0] ADDR_CPC = 32'h4003_B008;
    localparam logic [31:0] ADDR_QDC = 32'h4003_B00C;
    localparam logic [31:0] ADDR_RES = 32'h4003_B010;
    localparam logic [31:0] ADDR_CMPV = 32'h4003_B014;
    localparam logic [31:0] ADDR_PIC = 32'h4003_B018;
    localparam logic [31:0] ADDR_IRQ_STAT = 32'h4003_B01C;
    localparam logic [31:0] ADDR_IRQ_MASK = 32'h4003_B020;

    // ------------------------------------------------------------------
    // field positions and widths
    // ------------------------------------------------------------------
    localparam int SEL_W = 5;
    localparam int CCS_REPEAT_BIT = 5;
    localparam int CCS_IRQEN_BIT = 6;
    localparam int CCS_DONE_BIT = 7;
    localparam int CTC_REFSEL_W = 2;
    localparam int CTC_FULL_BIT = 2;
    localparam int CTC_EMPTY_BIT = 3;
    localparam int CTC_CMPGT_BIT = 4;
    localparam int CTC_CMPEN_BIT = 5;
    localparam int CTC_TRIG_BIT = 6;
    localparam int CTC_ACTIVE_BIT = 7;
    localparam int CPC_W = 8;
    localparam int QDEPTH_W = 3;
    localparam int QSLOTS = 8;
    localparam int QCNT_W = 4;
    localparam int RES_W = 12;
    localparam int PIC_W = 16;
    localparam int IRQ_W = 2;
    localparam int IRQ_DONE_BIT = 0;
    localparam int IRQ_ABORT_BIT = 1;

    // ------------------------------------------------------------------
    // reset values and codes
    // ------------------------------------------------------------------
    localparam logic [SEL_W-1:0] SEL_OFF = 5'h1F;
    localparam logic [31:0] CCS_RESET = 32'h0000_001F;
    localparam logic [31:0] CTC_RESET = 32'h0000_0008;
    localparam logic [IRQ_W-1:0] IRQ_MASK_RESET = 2'h1;

    typedef enum logic [0:0] {
        ST_IDLE = 1'b0,
        ST_CONV = 1'b1
    } adcs_state_t;

    // request to the analog converter core
    typedef struct packed {
        logic start;
        logic abort;
        logic [SEL_W-1:0] channel;
    } adcs_conv_req_t;

    // answer from the analog converter core
    typedef struct packed {
        logic done;
        logic [RES_W-1:0] data;
    } adcs_conv_rsp_t;

endpackage

`default_nettype wire

/* File: adcs_sequencer.sv */
/*
 * Conversion sequencer: APB register file, channel queue, start and
 * abort control, done flag and interrupt of a successive-approximation
 * converter.
 * Assumes the converter core runs on clk_sys, takes a one-cycle start
 * pulse and answers each started conversion that is not aborted with a one-cycle done pulse.
 */
`default_nettype none

module adcs_sequencer
    import adcs_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic hwTriggerIn,
    input wire adcs_conv_rsp_t convRsp,
    output adcs_conv_req_t convReq,
    output logic irqOut
);

    // ------------------------------------------------------------------
    // address decode
    // ------------------------------------------------------------------

    // full-word compare of a bus address with a register address
    function automatic logic isAddr(input logic [31:0] a,
                                    input logic [31:0] reg_addr);
        isAddr = (a == reg_addr);
    endfunction

    // ------------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------------
    logic [SEL_W-1:0] inputSelect;
    logic repeatMode;
    logic irqEnable;
    logic doneFlag;
    logic trigSel;
    logic cmpEn;
    logic cmpGt;
    logic [CTC_REFSEL_W-1:0] refSel;
    logic [CPC_W-1:0] clkPowerCfg;
    logic [QDEPTH_W-1:0] queueDepth;
    logic [RES_W-1:0] result;
    logic [RES_W-1:0] compareValue;
    logic [PIC_W-1:0] pinCtl;
    logic [IRQ_W-1:0] irqStatus;
    logic [IRQ_W-1:0] irqMask;
    adcs_state_t seqState;
    logic [QDEPTH_W-1:0] qIdx;
    logic [QCNT_W-1:0] qCount;
    logic [SEL_W-1:0] qMem [QSLOTS];
    logic abortEvt;
    logic hwMeta;
    logic hwSync;
    logic hwPrev;

    logic accessDone;
    logic wrEn;
    logic rdEn;
    logic setupPhase;
    logic wrCcs;
    logic rdRes;
    logic [SEL_W-1:0] wSel;
    logic queueMode;
    logic [QCNT_W-1:0] depthCnt;
    logic qFullNow;
    logic [QDEPTH_W-1:0] qWrIdx;
    logic [QCNT_W-1:0] next_qCount;
    logic [SEL_W-1:0] firstCh;
    logic pushing;
    logic swSetStart;
    logic lastOfSet;
    logic compareTrue;
    logic convEnd;
    logic setDone;
    logic hwEvent;
    logic [31:0] next_prdata;
    logic mapped;
    logic [IRQ_W-1:0] irqSet;
    logic [IRQ_W-1:0] irqClr;

    // ------------------------------------------------------------------
    // bus phases
    // ------------------------------------------------------------------

    // one access completes at the edge where pready is seen
    assign setupPhase = psel && !penable;
    assign accessDone = psel && penable && pready;
    assign wrEn = accessDone && pwrite;
    assign rdEn = accessDone && !pwrite;
    assign wrCcs = wrEn && isAddr(paddr, ADDR_CCS);
    assign rdRes = rdEn && isAddr(paddr, ADDR_RES);
    assign wSel = pwdata[SEL_W-1:0];

    // zero-wait answer: pready rises the cycle after setup
    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
        end
        else
        begin
            pready <= setupPhase;
            pslverr <= setupPhase && !mapped;
            if (setupPhase)
            begin
                prdata <= next_prdata;
            end
        end
    end

    // read mux; unmapped addresses read zero and flag an error
    always_comb
    begin
        next_prdata = 32'h0000_0000;
        mapped = 1'b1;
        if (isAddr(paddr, ADDR_CCS))
        begin
            // upper bits stay zero
            next_prdata[SEL_W-1:0] = inputSelect;
            next_prdata[CCS_REPEAT_BIT] = repeatMode;
            next_prdata[CCS_IRQEN_BIT] = irqEnable;
            next_prdata[CCS_DONE_BIT] = doneFlag;
        end
        else if (isAddr(paddr, ADDR_CTC))
        begin
            next_prdata[CTC_REFSEL_W-1:0] = refSel;
            next_prdata[CTC_FULL_BIT] = queueMode && qFullNow;
            next_prdata[CTC_EMPTY_BIT] = (qCount == 4'h0);
            next_prdata[CTC_CMPGT_BIT] = cmpGt;
            next_prdata[CTC_CMPEN_BIT] = cmpEn;
            next_prdata[CTC_TRIG_BIT] = trigSel;
            next_prdata[CTC_ACTIVE_BIT] = (seqState == ST_CONV);
        end
        else if (isAddr(paddr, ADDR_CPC))
        begin
            next_prdata[CPC_W-1:0] = clkPowerCfg;
        end
        else if (isAddr(paddr, ADDR_QDC))
        begin
            next_prdata[QDEPTH_W-1:0] = queueDepth;
        end
        else if (isAddr(paddr, ADDR_RES))
        begin
            next_prdata[RES_W-1:0] = result;
        end
        else if (isAddr(paddr, ADDR_CMPV))
        begin
            next_prdata[RES_W-1:0] = compareValue;
        end
        else if (isAddr(paddr, ADDR_PIC))
        begin
            next_prdata[PIC_W-1:0] = pinCtl;
        end
        else if (isAddr(paddr, ADDR_IRQ_STAT))
        begin
            next_prdata[IRQ_W-1:0] = irqStatus;
        end
        else if (isAddr(paddr, ADDR_IRQ_MASK))
        begin
            next_prdata[IRQ_W-1:0] = irqMask;
        end
        else
        begin
            mapped = 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // software registers
    // ------------------------------------------------------------------

    // control/status fields; bits above 7 are not stored
    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            inputSelect <= CCS_RESET[SEL_W-1:0];
            repeatMode <= CCS_RESET[CCS_REPEAT_BIT];
            irqEnable <= CCS_RESET[CCS_IRQEN_BIT];
        end
        else if (wrCcs)
        begin
            inputSelect <= wSel;
            repeatMode <= pwdata[CCS_REPEAT_BIT];
            irqEnable <= pwdata[CCS_IRQEN_BIT];
        end
    end

    // trigger and compare control
    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            trigSel <= CTC_RESET[CTC_TRIG_BIT];
            cmpEn <= CTC_RESET[CTC_CMPEN_BIT];
            cmpGt <= CTC_RESET[CTC_CMPGT_BIT];
            refSel <= CTC_RESET[CTC_REFSEL_W-1:0];
        end
        else if (wrEn && isAddr(paddr, ADDR_CTC))
        begin
            trigSel <= pwdata[CTC_TRIG_BIT];
            cmpEn <= pwdata[CTC_CMPEN_BIT];
            cmpGt <= pwdata[CTC_CMPGT_BIT];
            refSel <= pwdata[CTC_REFSEL_W-1:0];
        end
    end

    // plain storage registers
    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            clkPowerCfg <= '0;
            queueDepth <= '0;
            compareValue <= '0;
            pinCtl <= '0;
            irqMask <= IRQ_MASK_RESET;
        end
        else if (wrEn)
        begin
            if (isAddr(paddr, ADDR_CPC))
            begin
                clkPowerCfg <= pwdata[CPC_W-1:0];
            end
            if (isAddr(paddr, ADDR_QDC))
            begin
                queueDepth <= pwdata[QDEPTH_W-1:0];
            end
            if (isAddr(paddr, ADDR_CMPV))
            begin
                compareValue <= pwdata[RES_W-1:0];
            end
            if (isAddr(paddr, ADDR_PIC))
            begin
                pinCtl <= pwdata[PIC_W-1:0];
            end
            if (isAddr(paddr, ADDR_IRQ_MASK))
            begin
                irqMask <= pwdata[IRQ_W-1:0];
            end
        end
    end

    // ------------------------------------------------------------------
    // hardware trigger
    // ------------------------------------------------------------------

    // two-stage synchroniser, then a rising-edge detector
    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            hwMeta <= 1'b0;
            hwSync <= 1'b0;
            hwPrev <= 1'b0;
        end
        else
        begin
            hwMeta <= hwTriggerIn;
            hwSync <= hwMeta;
            hwPrev <= hwSync;
        end
    end

    assign hwEvent = trigSel && hwSync && !hwPrev;

    // ------------------------------------------------------------------
    // channel queue
    // ------------------------------------------------------------------

    // a full queue restarts from slot 0 on the next push
    assign queueMode = (queueDepth != 3'h0);
    assign depthCnt = {1'b0, queueDepth};
    assign qFullNow = (qCount >= depthCnt);
    assign qWrIdx = qFullNow ? 3'h0 : qCount[QDEPTH_W-1:0];
    assign next_qCount = qFullNow ? 4'h1 : qCount + 4'h1;
    assign firstCh = (qWrIdx == 3'h0) ? wSel : qMem[0];
    assign pushing = wrCcs && queueMode && (wSel != SEL_OFF);
    assign swSetStart = pushing && !trigSel
        && (next_qCount == depthCnt);
    assign lastOfSet = ({1'b0, qIdx} == depthCnt - 4'h1);

    // one storage slot per queue entry, written in arrival order
    genvar gi;
    generate
        for (gi = 0; gi < QSLOTS; gi++)
        begin : g_slot
            always_ff @(posedge clk_sys)
            begin
                if (!rst_n)
                begin
                    qMem[gi] <= SEL_OFF;
                end
                else if (pushing && (qWrIdx == QDEPTH_W'(gi)))
                begin
                    qMem[gi] <= wSel;
                end
            end
        end
    endgenerate

    // ------------------------------------------------------------------
    // conversion sequencer
    // ------------------------------------------------------------------
    assign convEnd = (seqState == ST_CONV) && convRsp.done;

    // start, abort, queue walk and repeat loop
    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            seqState <= ST_IDLE;
            qIdx <= '0;
            qCount <= '0;
            convReq <= '{start: 1'b0, abort: 1'b0, channel: SEL_OFF};
            abortEvt <= 1'b0;
        end
        else
        begin
            convReq.start <= 1'b0;
            convReq.abort <= 1'b0;
            abortEvt <= 1'b0;
            if (wrCcs)
            begin
                // any write cuts a running conversion
                if (seqState == ST_CONV)
                begin
                    convReq.abort <= 1'b1;
                    abortEvt <= 1'b1;
                end
                seqState <= ST_IDLE;
                if (wSel == SEL_OFF)
                begin
                    qCount <= '0;
                end
                else if (queueMode)
                begin
                    qCount <= next_qCount;
                    if (swSetStart)
                    begin
                        seqState <= ST_CONV;
                        qIdx <= '0;
                        convReq.start <= 1'b1;
                        convReq.channel <= firstCh;
                    end
                end
                else if (!trigSel)
                begin
                    seqState <= ST_CONV;
                    convReq.start <= 1'b1;
                    convReq.channel <= wSel;
                end
            end
            else if (hwEvent && seqState == ST_IDLE)
            begin
                // one edge starts one conversion or one set
                if (queueMode)
                begin
                    if (qCount == depthCnt)
                    begin
                        seqState <= ST_CONV;
                        qIdx <= '0;
                        convReq.start <= 1'b1;
                        convReq.channel <= qMem[0];
                    end
                end
                else if (inputSelect != SEL_OFF)
                begin
                    seqState <= ST_CONV;
                    convReq.start <= 1'b1;
                    convReq.channel <= inputSelect;
                end
            end
            else if (convEnd)
            begin
                if (queueMode && !lastOfSet)
                begin
                    qIdx <= qIdx + 3'h1;
                    convReq.start <= 1'b1;
                    convReq.channel <= qMem[qIdx + 3'h1];
                end
                else if (repeatMode)
                begin
                    // loop the set or the single channel
                    qIdx <= '0;
                    convReq.start <= 1'b1;
                    convReq.channel <= queueMode ? qMem[0] : inputSelect;
                end
                else
                begin
                    seqState <= ST_IDLE;
                    if (queueMode && !trigSel)
                    begin
                        qCount <= '0;
                    end
                end
            end
        end
    end

    // ------------------------------------------------------------------
    // result and done flag
    // ------------------------------------------------------------------
    assign compareTrue = cmpGt ? (convRsp.data >= compareValue)
                               : (convRsp.data < compareValue);

    // done only at set end in queue mode, and only on a compare hit when cmpEn is set
    assign setDone = convEnd
        && (!queueMode || lastOfSet)
        && (!cmpEn || compareTrue);

    // result capture on every completed conversion
    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            result <= '0;
        end
        else if (convEnd)
        begin
            result <= convRsp.data;
        end
    end

    // set wins over a same-cycle clear
    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            doneFlag <= CCS_RESET[CCS_DONE_BIT];
        end
        else if (setDone)
        begin
            doneFlag <= 1'b1;
        end
        else if (wrCcs || rdRes)
        begin
            doneFlag <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // interrupt
    // ------------------------------------------------------------------
    assign irqSet = {abortEvt, setDone && irqEnable};
    assign irqClr = (wrEn && isAddr(paddr, ADDR_IRQ_STAT))
        ? pwdata[IRQ_W-1:0] : '0;

    // sticky status, write one to clear, set has priority
    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            irqStatus <= '0;
            irqOut <= 1'b0;
        end
        else
        begin
            irqStatus <= (irqStatus & ~irqClr) | irqSet;
            irqOut <= |(irqStatus & irqMask);
        end
    end

endmodule

`default_nettype wire

/* File: adcs_sequencer_chk.sv */
/*
 * Port-level assertions for the conversion sequencer.
 * Assumes one clock domain; bound to adcs_sequencer at the foot.
 */
`default_nettype none

module adcs_sequencer_chk
    import adcs_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic hwTriggerIn,
    input wire adcs_conv_rsp_t convRsp,
    input wire adcs_conv_req_t convReq,
    input wire logic irqOut
);
    timeunit 1ns;
    timeprecision 1ps;

    default clocking dcb @(posedge clk_sys);
    endclocking
    default disable iff (!rst_n);

    // conversion started and not yet ended or aborted
    logic busy;
    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
            busy <= 1'b0;
        else if (convReq.start)
            busy <= 1'b1;
        else if (convRsp.done || convReq.abort)
            busy <= 1'b0;
    end

    // --------------------------------------------------------------
    // bus phases
    // --------------------------------------------------------------
    sequence s_setup;
        psel && !penable;
    endsequence
    sequence s_ccs_wr;
        psel && penable && pready && pwrite && paddr == ADDR_CCS;
    endsequence

    a_setup_ready: assert property (s_setup |=> pready)
        else $error("ready missing after setup");
    a_ready_cause: assert property (pready |-> $past(psel) && !$past(penable))
        else $error("ready without a setup cycle");
    a_off_no_start: assert property (s_ccs_wr ##0
        (pwdata[SEL_W-1:0] == SEL_OFF) |=> !convReq.start [*3])
        else $error("start after disable code");
    a_write_aborts: assert property (s_ccs_wr ##0
        (busy && !convRsp.done) |-> ##[1:2] convReq.abort)
        else $error("running conversion not aborted");
    a_ccs_upper_zero: assert property (s_setup ##0
        (!pwrite && paddr == ADDR_CCS) |=> prdata[31:8] == 24'h000000)
        else $error("upper control bits not zero");
    a_unmapped_err: assert property (s_setup ##0
        (!pwrite && paddr > ADDR_IRQ_MASK) |=> pslverr && prdata == 32'h0)
        else $error("unmapped read not refused");
    a_start_pulse: assert property (convReq.start |=> !convReq.start)
        else $error("start longer than one cycle");
    a_chan_hold: assert property
        (convReq.channel != $past(convReq.channel) |-> convReq.start)
        else $error("channel changed without start");
endmodule

bind adcs_sequencer adcs_sequencer_chk adcs_sequencer_chk_inst (
    .clk_sys(clk_sys), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .hwTriggerIn(hwTriggerIn),
    .convRsp(convRsp), .convReq(convReq), .irqOut(irqOut));

`default_nettype wire

/* File: adcs_core_model.sv */
/*
 * Behavioural converter core facing the sequencer.
 * Assumes one-cycle start and abort pulses on clk_sys.
 */
`default_nettype none

module adcs_core_model
    import adcs_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic slow,
    input wire adcs_conv_req_t convReq,
    output adcs_conv_rsp_t convRsp
);
    timeunit 1ns;
    timeprecision 1ps;

    logic run;
    logic [7:0] cnt;
    logic [SEL_W-1:0] ch;
    logic [RES_W-1:0] last;

    // counts down, then answers with the channel in the top five result bits
    always_ff @(posedge clk_sys)
    begin
        convRsp.done <= 1'b0;
        convRsp.data <= ~last; // idle data never repeats the result
        if (!rst_n)
        begin
            run <= 1'b0;
            last <= 12'hAAA;
        end
        else if (convReq.start)
        begin
            run <= 1'b1;
            cnt <= slow ? 8'h28 : 8'h04;
            ch <= convReq.channel;
        end
        else if (convReq.abort)
            run <= 1'b0;
        else if (run && cnt == 8'h00)
        begin
            run <= 1'b0;
            convRsp.done <= 1'b1;
            convRsp.data <= {ch, 7'h00};
            last <= {ch, 7'h00};
        end
        else if (run)
            cnt <= cnt - 8'h01;
    end
endmodule

`default_nettype wire

/* File: tb.sv */
/*
 * Self-checking bench for the conversion sequencer.
 * Assumes the core model answers each start that is not aborted with one done pulse.
 */
`default_nettype none

module tb
    import adcs_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    typedef struct {
        logic [31:0] a, r;
        logic w;
        logic [31:0] b;
    } adcs_row_t;

    logic clk_sys, rst_n, psel, penable, pwrite, pready, pslverr;
    logic hwTriggerIn, slow, irqOut, lastErr;
    logic [31:0] paddr, pwdata, prdata;
    adcs_conv_rsp_t convRsp;
    adcs_conv_req_t convReq;
    logic [SEL_W-1:0] chQ[$];
    int nStart, nDone, failCount, nCompared, cycles, k;
    adcs_row_t rows [10] = '{
        '{ADDR_CCS, 32'h0000_001F, 1'b0, 32'h0},
        '{ADDR_CTC, 32'h0000_0008, 1'b0, 32'h0},
        '{ADDR_CPC, 32'h0, 1'b1, 32'h0000_00FF},
        '{ADDR_QDC, 32'h0, 1'b0, 32'h0},
        '{ADDR_RES, 32'h0, 1'b1, 32'h0},
        '{ADDR_CMPV, 32'h0, 1'b1, 32'h0000_0FFF},
        '{ADDR_PIC, 32'h0, 1'b1, 32'h0000_FFFF},
        '{ADDR_IRQ_STAT, 32'h0, 1'b0, 32'h0},
        '{ADDR_IRQ_MASK, 32'h0000_0001, 1'b1, 32'h0000_0003},
        '{32'h4003_B030, 32'h0, 1'b1, 32'h0}};

    adcs_sequencer adcs_sequencer_inst (.clk_sys(clk_sys), .rst_n(rst_n),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .hwTriggerIn(hwTriggerIn), .convRsp(convRsp),
        .convReq(convReq), .irqOut(irqOut));
    adcs_core_model adcs_core_model_inst (.clk_sys(clk_sys),
        .rst_n(rst_n), .slow(slow), .convReq(convReq), .convRsp(convRsp));

    // clock, cycle limit and start/done monitor
    initial
    begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end
    always @(posedge clk_sys)
    begin
        cycles++;
        if (rst_n === 1'b1 && convReq.start === 1'b1)
            chQ.push_back(convReq.channel);
        nStart = chQ.size();
        if (rst_n === 1'b1 && convRsp.done === 1'b1)
            nDone++;
        if (cycles == 20000)
        begin
            failCount++;
            endSim();
        end
    end

    // --------------------------------------------------------------
    // tasks
    // --------------------------------------------------------------
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        nCompared++;
        if (got !== exp)
        begin
            failCount++;
            $display("wrong value at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [31:0] a,
        input logic [31:0] d, output logic [31:0] q);
        int n = 0;
        @(posedge clk_sys);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        do
        begin
            @(posedge clk_sys);
            n++;
        end
        while (pready !== 1'b1 && n < 50);
        q = prdata;
        lastErr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        check({31'h0, n < 50}, 32'h1);
    endtask
    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        logic [31:0] q;
        apb(1'b1, a, d, q);
    endtask
    task automatic rdc(input logic [31:0] a, input logic [31:0] exp);
        logic [31:0] q;
        apb(1'b0, a, 32'h0, q);
        check(q, exp);
    endtask
    task automatic waitCnt(ref int c, input int want);
        int n = 0;
        while (c < want && n < 500)
        begin
            @(posedge clk_sys);
            n++;
        end
        check(32'(c), 32'(want));
    endtask
    task automatic endSim();
        $display("compared %0d mismatches %0d", nCompared, failCount);
        if (failCount == 0 && nCompared > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    // --------------------------------------------------------------
    // main sequence
    // --------------------------------------------------------------
    initial
    begin
        {rst_n, psel, penable, pwrite, hwTriggerIn, slow} = 6'h00;
        paddr = 32'h0;
        pwdata = 32'h0;
        repeat (12) @(posedge clk_sys);
        rst_n <= 1'b1;
        foreach (rows[i])
        begin
            rdc(rows[i].a, rows[i].r);
            if (rows[i].w)
            begin
                wr(rows[i].a, 32'hFFFF_FFFF);
                rdc(rows[i].a, rows[i].b);
            end
        end
        check({31'h0, lastErr}, 32'h1);
        // single software conversion with interrupt
        wr(ADDR_CCS, 32'h0000_0043);
        waitCnt(nDone, 1);
        rdc(ADDR_CCS, 32'h0000_00C3);
        check({31'h0, irqOut}, 32'h1);
        rdc(ADDR_RES, 32'h0000_0180);
        rdc(ADDR_CCS, 32'h0000_0043);
        rdc(ADDR_IRQ_STAT, 32'h0000_0001);
        wr(ADDR_IRQ_STAT, 32'h0000_0001);
        rdc(ADDR_IRQ_STAT, 32'h0);
        check({31'h0, irqOut}, 32'h0);
        check(32'(nStart), 32'h1);
        // abort by rewrite, then disable code
        slow <= 1'b1;
        wr(ADDR_CCS, 32'h0000_0005);
        waitCnt(nStart, 2);
        rdc(ADDR_CTC, 32'h0000_0088);
        wr(ADDR_CCS, 32'h0000_0006);
        waitCnt(nStart, 3);
        check(32'(chQ[2]), 32'h6);
        wr(ADDR_CCS, 32'h0000_001F);
        rdc(ADDR_CTC, 32'h0000_0008);
        rdc(ADDR_IRQ_STAT, 32'h0000_0002);
        wr(ADDR_IRQ_STAT, 32'h0000_0003);
        check(32'(nStart), 32'h3);
        // compare less-than: pass on channel 3, fail on channel 5
        slow <= 1'b0;
        wr(ADDR_CMPV, 32'h0000_0200);
        wr(ADDR_CTC, 32'h0000_0020);
        for (int i = 0; i < 2; i++)
        begin
            wr(ADDR_CCS, i ? 32'h05 : 32'h03);
            waitCnt(nDone, 2 + i);
            rdc(ADDR_CCS, i ? 32'h05 : 32'h83);
        end
        // queue of three, written in order
        wr(ADDR_CTC, 32'h0);
        slow <= 1'b1;
        wr(ADDR_QDC, 32'h0000_0003);
        wr(ADDR_CCS, 32'h0000_0001);
        wr(ADDR_CCS, 32'h0000_0002);
        check(32'(nStart), 32'h5);
        wr(ADDR_CCS, 32'h0000_0004);
        waitCnt(nDone, 4);
        rdc(ADDR_CCS, 32'h0000_0004);
        waitCnt(nDone, 6);
        rdc(ADDR_CCS, 32'h0000_0084);
        check({chQ[5], chQ[6], chQ[7]}, 32'h0000_0444);
        check(32'(nStart), 32'h8);
        // queue set looping in repeat mode
        for (int i = 0; i < 3; i++)
            wr(ADDR_CCS, 32'h0000_0020 | (32'h1 << i));
        waitCnt(nStart, 12);
        check(32'(chQ[11]), 32'h1);
        wr(ADDR_QDC, 32'h0);
        // repeat mode until disabled
        slow <= 1'b0;
        wr(ADDR_CCS, 32'h0000_0027);
        waitCnt(nStart, nStart + 3);
        wr(ADDR_CCS, 32'h0000_001F);
        repeat (3) @(posedge clk_sys);
        k = nStart;
        repeat (20) @(posedge clk_sys);
        check(32'(nStart), 32'(k));
        // hardware trigger: write alone starts nothing, one rise one start
        wr(ADDR_CTC, 32'h0000_0040);
        wr(ADDR_CCS, 32'h0000_0002);
        repeat (10) @(posedge clk_sys);
        check(32'(nStart), 32'(k));
        hwTriggerIn <= 1'b1;
        waitCnt(nStart, k + 1);
        repeat (30) @(posedge clk_sys);
        check(32'(nStart), 32'(k + 1));
        endSim();
    end
endmodule

`default_nettype wire
